// *** logic/ocs_pkg.sv ***
// constants, types and helpers for the output clock stop and select block
//
// Contract
// - output three takes general divider d on code 00, precision divider d on 01.
// - differential pair two/three ignores the select field; three is inverted two.
// - general divider a halt field stops output zero low or high.
// - general divider b halt field stops output one low or high.
// - general divider c halt field stops output two low or high.
// - general divider d halt field stops output three low or high.
// - precision divider c halt field stops precision output zero low or high.
// - precision divider d halt field stops precision output one; reversed on configurable outputs.
package ocs_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    localparam logic [ADDR_W-1:0] OUTPUT_SELECT_LOW_GROUP_ADDR = 8'hb5;
    localparam logic [ADDR_W-1:0] SYNTH_ONE_OUTPUT_HALT_ADDR   = 8'hb7;
    localparam logic [ADDR_W-1:0] SYNTH_ZERO_OUTPUT_HALT_ADDR  = 8'hb8;
    localparam logic [ADDR_W-1:0] LOCK_LOSS_STICKY_FLAGS_ADDR  = 8'hb9;

    localparam logic [DATA_W-1:0] REG_RESET  = 8'h00;
    localparam logic [DATA_W-1:0] READ_ZERO  = 8'h00;

    // ------------------------------------------------------------------
    // field positions (low bit of each two-bit field)
    // ------------------------------------------------------------------
    localparam int unsigned FIELD_W          = 2;
    localparam int unsigned SEL_THREE_LSB    = 6;
    localparam int unsigned GEN_DIV_A_LSB    = 0;
    localparam int unsigned GEN_DIV_B_LSB    = 2;
    localparam int unsigned GEN_DIV_C_LSB    = 4;
    localparam int unsigned GEN_DIV_D_LSB    = 6;
    localparam int unsigned PREC_DIV_C_LSB   = 0;
    localparam int unsigned PREC_DIV_D_LSB   = 2;
    localparam int unsigned PREC_USED_W      = 4;  // bits 7:4 reserved, read zero
    localparam int unsigned LOCK_FLAGS_W     = 4;  // bits 7:4 reserved, read zero

    // ------------------------------------------------------------------
    // field codes
    // ------------------------------------------------------------------
    localparam logic [FIELD_W-1:0] SEL_GENERAL_D   = 2'h0;
    localparam logic [FIELD_W-1:0] SEL_PRECISION_D = 2'h1;
    localparam logic [FIELD_W-1:0] HALT_RUN_A      = 2'h0;
    localparam logic [FIELD_W-1:0] HALT_RUN_B      = 2'h1;
    localparam logic [FIELD_W-1:0] HALT_LOW        = 2'h2;
    localparam logic [FIELD_W-1:0] HALT_HIGH       = 2'h3;

    localparam logic OUT_RESET = 1'b0;

    // one-hot halt modes
    typedef enum logic [2:0] {
        MODE_RUN  = 3'b001,
        MODE_LOW  = 3'b010,
        MODE_HIGH = 3'b100
    } ocs_mode_e;

    // decode a two-bit halt field into its mode
    function automatic ocs_mode_e ocs_halt_mode(input logic [FIELD_W-1:0] code);
        ocs_mode_e m;
        m = MODE_RUN;
        unique case (code)
            HALT_RUN_A: m = MODE_RUN;
            HALT_RUN_B: m = MODE_RUN;
            HALT_LOW:   m = MODE_LOW;
            HALT_HIGH:  m = MODE_HIGH;
        endcase
        return m;
    endfunction

    // swap the stop polarity of a mode
    function automatic ocs_mode_e ocs_mode_flip(input ocs_mode_e m);
        ocs_mode_e r;
        r = m;
        unique case (m)
            MODE_RUN:  r = MODE_RUN;
            MODE_LOW:  r = MODE_HIGH;
            MODE_HIGH: r = MODE_LOW;
            default:   r = MODE_RUN;
        endcase
        return r;
    endfunction

endpackage

// *** logic/ocs_halt_next.sv ***
// next output level of one halt-controlled clock path
`timescale 1ns/1ps
module ocs_halt_next
    import ocs_pkg::*;
(
    input  wire logic      src,
    input  wire logic      cur,
    input  wire ocs_mode_e mode,
    output logic           nxt
);

    // ------------------------------------------------------------------
    // gating: stop-low lets only falling edges through, stop-high only
    // rising ones, so the output settles at the held level without a
    // runt pulse and resumes from it once mode returns to run
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt = src;
        unique case (mode)
            MODE_RUN:  nxt = src;
            MODE_LOW:  nxt = cur & src;
            MODE_HIGH: nxt = cur | src;
            default:   nxt = src;
        endcase
    end

endmodule // ocs_halt_next

// *** logic/ocs_regs.sv ***
// configuration register file for the output clock stop and select block
`timescale 1ns/1ps
module ocs_regs
    import ocs_pkg::*;
(
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    input  wire logic                          reg_wr_en,
    input  wire logic                          reg_rd_en,
    input  wire logic [ocs_pkg::ADDR_W-1:0]    reg_addr,
    input  wire logic [ocs_pkg::DATA_W-1:0]    reg_wdata,
    input  wire logic [ocs_pkg::LOCK_FLAGS_W-1:0] lock_loss_flags,
    output logic [ocs_pkg::DATA_W-1:0]         reg_rdata,
    output logic [ocs_pkg::DATA_W-1:0]         sel_reg,
    output logic [ocs_pkg::DATA_W-1:0]         gen_halt_reg,
    output logic [ocs_pkg::DATA_W-1:0]         prec_halt_reg
);

    logic [DATA_W-1:0]       sel_q,  sel_d;
    logic [DATA_W-1:0]       gen_q,  gen_d;
    logic [PREC_USED_W-1:0]  prec_q, prec_d;
    logic [DATA_W-1:0]       rdata_q, rdata_d;

    // ------------------------------------------------------------------
    // write decode and read mux; unmapped reads return zero
    // ------------------------------------------------------------------
    always_comb
    begin
        sel_d   = sel_q;
        gen_d   = gen_q;
        prec_d  = prec_q;
        rdata_d = rdata_q;
        if (reg_wr_en)
        begin
            unique case (reg_addr)
                OUTPUT_SELECT_LOW_GROUP_ADDR: sel_d  = reg_wdata;
                SYNTH_ONE_OUTPUT_HALT_ADDR:   gen_d  = reg_wdata;
                SYNTH_ZERO_OUTPUT_HALT_ADDR:  prec_d = reg_wdata[PREC_USED_W-1:0];
                default:                      ;   // read-only or unmapped
            endcase
        end
        if (reg_rd_en)
        begin
            unique case (reg_addr)
                OUTPUT_SELECT_LOW_GROUP_ADDR: rdata_d = sel_q;
                SYNTH_ONE_OUTPUT_HALT_ADDR:   rdata_d = gen_q;
                SYNTH_ZERO_OUTPUT_HALT_ADDR:  rdata_d = {{(DATA_W-PREC_USED_W){1'b0}}, prec_q};
                LOCK_LOSS_STICKY_FLAGS_ADDR:
                    rdata_d = {{(DATA_W-LOCK_FLAGS_W){1'b0}}, lock_loss_flags};
                default:                      rdata_d = READ_ZERO;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // register update
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sel_q   <= REG_RESET;
            gen_q   <= REG_RESET;
            prec_q  <= REG_RESET[PREC_USED_W-1:0];
            rdata_q <= REG_RESET;
        end
        else
        begin
            sel_q   <= sel_d;
            gen_q   <= gen_d;
            prec_q  <= prec_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata     = rdata_q;
    assign sel_reg       = sel_q;
    assign gen_halt_reg  = gen_q;
    assign prec_halt_reg = {{(DATA_W-PREC_USED_W){1'b0}}, prec_q};

endmodule // ocs_regs

// *** logic/ocs_top.sv ***
// output clock routing and stop control top level
`timescale 1ns/1ps
module ocs_top
    import ocs_pkg::*;
#(
    parameter int unsigned REG_ADDR_W = ocs_pkg::ADDR_W,
    parameter int unsigned REG_DATA_W = ocs_pkg::DATA_W
)
(
    input  wire logic                              clk,
    input  wire logic                              rst_n,
    // register port
    input  wire logic                              reg_wr_en,
    input  wire logic                              reg_rd_en,
    input  wire logic [REG_ADDR_W-1:0]             reg_addr,
    input  wire logic [REG_DATA_W-1:0]             reg_wdata,
    output logic      [REG_DATA_W-1:0]             reg_rdata,
    // synthesizer post divider clocks, sampled on clk
    input  wire logic                              general_div_a,
    input  wire logic                              general_div_b,
    input  wire logic                              general_div_c,
    input  wire logic                              general_synth_divider_d,
    input  wire logic                              precision_div_c,
    input  wire logic                              precision_synth_divider_d,
    // pair two/three driven differentially
    input  wire logic                              pair_two_three_diff,
    // lock loss indications shown in the status register
    input  wire logic [ocs_pkg::LOCK_FLAGS_W-1:0]  lock_loss_flags,
    // output clocks
    output logic                                   config_output_zero,
    output logic                                   config_output_one,
    output logic                                   config_output_two,
    output logic                                   config_output_three,
    output logic                                   precision_output_zero,
    output logic                                   precision_output_one
);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (REG_ADDR_W != ADDR_W || REG_DATA_W != DATA_W)
    begin : g_bad_width
        $error("register port widths must match the register map");
    end

    logic [DATA_W-1:0]  sel_reg;
    logic [DATA_W-1:0]  gen_halt_reg;
    logic [DATA_W-1:0]  prec_halt_reg;

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    ocs_regs u_regs (
        .clk             (clk),
        .rst_n           (rst_n),
        .reg_wr_en       (reg_wr_en),
        .reg_rd_en       (reg_rd_en),
        .reg_addr        (reg_addr),
        .reg_wdata       (reg_wdata),
        .lock_loss_flags (lock_loss_flags),
        .reg_rdata       (reg_rdata),
        .sel_reg         (sel_reg),
        .gen_halt_reg    (gen_halt_reg),
        .prec_halt_reg   (prec_halt_reg)
    );

    // ------------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------------
    logic [FIELD_W-1:0] sel_three;
    ocs_mode_e          mode_gen_a;
    ocs_mode_e          mode_gen_b;
    ocs_mode_e          mode_gen_c;
    ocs_mode_e          mode_gen_d;
    ocs_mode_e          mode_prec_c;
    ocs_mode_e          mode_prec_d;

    assign sel_three   = sel_reg[SEL_THREE_LSB +: FIELD_W];
    assign mode_gen_a  = ocs_halt_mode(gen_halt_reg[GEN_DIV_A_LSB +: FIELD_W]);
    assign mode_gen_b  = ocs_halt_mode(gen_halt_reg[GEN_DIV_B_LSB +: FIELD_W]);
    assign mode_gen_c  = ocs_halt_mode(gen_halt_reg[GEN_DIV_C_LSB +: FIELD_W]);
    assign mode_gen_d  = ocs_halt_mode(gen_halt_reg[GEN_DIV_D_LSB +: FIELD_W]);
    assign mode_prec_c = ocs_halt_mode(prec_halt_reg[PREC_DIV_C_LSB +: FIELD_W]);
    assign mode_prec_d = ocs_halt_mode(prec_halt_reg[PREC_DIV_D_LSB +: FIELD_W]);

    // ------------------------------------------------------------------
    // output three source: general d on 00, precision d (stop level
    // reversed) on 01, held low on reserved codes
    // ------------------------------------------------------------------
    logic      three_src;
    ocs_mode_e three_mode;

    always_comb
    begin
        three_src  = general_synth_divider_d;
        three_mode = mode_gen_d;
        unique case (sel_three)
            SEL_GENERAL_D:
            begin
                three_src  = general_synth_divider_d;
                three_mode = mode_gen_d;
            end
            SEL_PRECISION_D:
            begin
                three_src  = precision_synth_divider_d;
                three_mode = ocs_mode_flip(mode_prec_d);
            end
            default:
            begin
                three_src  = OUT_RESET;
                three_mode = MODE_LOW;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // next levels of every output
    // ------------------------------------------------------------------
    logic cfg0_q, cfg1_q, cfg2_q, cfg3_q, prec0_q, prec1_q;
    logic cfg0_d, cfg1_d, cfg2_d, cfg3_d, prec0_d, prec1_d;
    logic three_single_d;

    ocs_halt_next u_cfg0 (
        .src  (general_div_a),
        .cur  (cfg0_q),
        .mode (mode_gen_a),
        .nxt  (cfg0_d)
    );

    ocs_halt_next u_cfg1 (
        .src  (general_div_b),
        .cur  (cfg1_q),
        .mode (mode_gen_b),
        .nxt  (cfg1_d)
    );

    ocs_halt_next u_cfg2 (
        .src  (general_div_c),
        .cur  (cfg2_q),
        .mode (mode_gen_c),
        .nxt  (cfg2_d)
    );

    ocs_halt_next u_cfg3 (
        .src  (three_src),
        .cur  (cfg3_q),
        .mode (three_mode),
        .nxt  (three_single_d)
    );

    ocs_halt_next u_prec0 (
        .src  (precision_div_c),
        .cur  (prec0_q),
        .mode (mode_prec_c),
        .nxt  (prec0_d)
    );

    ocs_halt_next u_prec1 (
        .src  (precision_synth_divider_d),
        .cur  (prec1_q),
        .mode (mode_prec_d),
        .nxt  (prec1_d)
    );

    // differential pair: select field ignored, three mirrors two inverted
    always_comb
    begin
        cfg3_d = three_single_d;
        if (pair_two_three_diff)
        begin
            cfg3_d = ~cfg2_d;
        end
    end

    // ------------------------------------------------------------------
    // output flops; all outputs launch on the same edge
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cfg0_q  <= OUT_RESET;
            cfg1_q  <= OUT_RESET;
            cfg2_q  <= OUT_RESET;
            cfg3_q  <= OUT_RESET;
            prec0_q <= OUT_RESET;
            prec1_q <= OUT_RESET;
        end
        else
        begin
            cfg0_q  <= cfg0_d;
            cfg1_q  <= cfg1_d;
            cfg2_q  <= cfg2_d;
            cfg3_q  <= cfg3_d;
            prec0_q <= prec0_d;
            prec1_q <= prec1_d;
        end
    end

    assign config_output_zero    = cfg0_q;
    assign config_output_one     = cfg1_q;
    assign config_output_two     = cfg2_q;
    assign config_output_three   = cfg3_q;
    assign precision_output_zero = prec0_q;
    assign precision_output_one  = prec1_q;

endmodule // ocs_top

// *** test/ocs_props.sv ***
// concurrent checks on the ports of the output clock stop and select top
`timescale 1ns/1ps
module ocs_props
    import ocs_pkg::*;
#(
    parameter int unsigned REG_ADDR_W = 8,
    parameter int unsigned REG_DATA_W = 8
)
(
    input wire logic                  clk,
    input wire logic                  rst_n,
    input wire logic                  reg_wr_en,
    input wire logic [REG_ADDR_W-1:0] reg_addr,
    input wire logic [REG_DATA_W-1:0] reg_wdata,
    input wire logic                  general_div_a,
    input wire logic                  general_synth_divider_d,
    input wire logic                  precision_div_c,
    input wire logic                  precision_synth_divider_d,
    input wire logic                  pair_two_three_diff,
    input wire logic                  config_output_zero,
    input wire logic                  config_output_one,
    input wire logic                  config_output_two,
    input wire logic                  config_output_three,
    input wire logic                  precision_output_zero,
    input wire logic                  precision_output_one
);
    logic [REG_DATA_W-1:0] sel_q, sel_d, gh_q, gh_d, ph_q, ph_d;

    // next level of a path: run follows source, low ands, high ors
    function automatic logic nx(input logic [1:0] c, input logic cur, input logic s);
        return (c == 2'h2) ? (cur & s) : (c == 2'h3) ? (cur | s) : s;
    endfunction

    // stop polarity swapped when a precision clock feeds output three
    function automatic logic [1:0] rv(input logic [1:0] c);
        return c[1] ? {1'b1, ~c[0]} : c;
    endfunction

    // ----------------------------------------------------------------
    // shadow of the three control registers
    // ----------------------------------------------------------------
    always_comb
    begin
        sel_d = sel_q;
        gh_d  = gh_q;
        ph_d  = ph_q;
        if (reg_wr_en && reg_addr == OUTPUT_SELECT_LOW_GROUP_ADDR) sel_d = reg_wdata;
        if (reg_wr_en && reg_addr == SYNTH_ONE_OUTPUT_HALT_ADDR) gh_d = reg_wdata;
        if (reg_wr_en && reg_addr == SYNTH_ZERO_OUTPUT_HALT_ADDR) ph_d = reg_wdata;
    end

    // registers only; cleared by reset like the design
    always_ff @(posedge clk)
    begin
        sel_q <= rst_n ? sel_d : 8'h00;
        gh_q  <= rst_n ? gh_d : 8'h00;
        ph_q  <= rst_n ? ph_d : 8'h00;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    zero_path_a: assert property ($past(rst_n) |-> config_output_zero ==
        nx($past(gh_q[1:0]), $past(config_output_zero), $past(general_div_a)))
        else $error("output zero off its path");
    one_low_a: assert property (gh_q[3:2] == HALT_LOW && !config_output_one
        |=> !config_output_one) else $error("output one left its low hold");
    two_high_a: assert property (gh_q[5:4] == HALT_HIGH && config_output_two
        |=> config_output_two) else $error("output two left its high hold");
    three_gen_a: assert property ($past(rst_n) && !$past(pair_two_three_diff)
        && $past(sel_q[7:6]) == SEL_GENERAL_D |-> config_output_three == nx($past(gh_q[7:6]),
        $past(config_output_three), $past(general_synth_divider_d)))
        else $error("output three off general path");
    three_prec_a: assert property ($past(rst_n) && !$past(pair_two_three_diff)
        && $past(sel_q[7:6]) == SEL_PRECISION_D |-> config_output_three == nx(rv($past(ph_q[3:2])),
        $past(config_output_three), $past(precision_synth_divider_d)))
        else $error("output three off precision path");
    three_resv_a: assert property ($past(rst_n) && !$past(pair_two_three_diff)
        && $past(sel_q[7]) |-> !config_output_three) else $error("reserved select not low");
    diff_inv_a: assert property ($past(rst_n) && $past(pair_two_three_diff)
        |-> config_output_three != config_output_two) else $error("pair not inverted");
    prec_zero_a: assert property ($past(rst_n) |-> precision_output_zero ==
        nx($past(ph_q[1:0]), $past(precision_output_zero), $past(precision_div_c)))
        else $error("precision output zero off its path");
    prec_one_a: assert property ((ph_q[3:2] == HALT_LOW && !precision_output_one)[*2]
        |=> !precision_output_one) else $error("precision output one left low hold");
    hold_steady_a: assert property (gh_q[1:0] == HALT_HIGH && config_output_zero
        |=> $stable(config_output_zero)) else $error("held output zero moved");
endmodule // ocs_props

bind ocs_top ocs_props #(.REG_ADDR_W(REG_ADDR_W), .REG_DATA_W(REG_DATA_W)) u_ocs_props (
    .clk(clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .general_div_a(general_div_a),
    .general_synth_divider_d(general_synth_divider_d), .precision_div_c(precision_div_c),
    .precision_synth_divider_d(precision_synth_divider_d),
    .pair_two_three_diff(pair_two_three_diff), .config_output_zero(config_output_zero),
    .config_output_one(config_output_one), .config_output_two(config_output_two),
    .config_output_three(config_output_three), .precision_output_zero(precision_output_zero),
    .precision_output_one(precision_output_one));

// *** test/ocs_div_model.sv ***
// post divider clock sources of both synthesizers
`timescale 1ns/1ps
module ocs_div_model
(
    input wire logic clk,
    input wire logic rst_n,
    output logic     div_a,
    output logic     div_b,
    output logic     div_c,
    output logic     gen_d,
    output logic     prec_c,
    output logic     prec_d
);
    logic [3:0] cnt_q, cnt_d;

    // free running count; held at zero while reset is low
    always_comb cnt_d = rst_n ? cnt_q + 4'h1 : 4'h0;

    // sources change away from the sampling edge
    always_ff @(negedge clk) cnt_q <= cnt_d;

    // each divider routed to its own output
    assign div_a  = cnt_q[1];
    assign div_b  = cnt_q[2];
    assign div_c  = cnt_q[0];
    assign gen_d  = cnt_q[3];
    assign prec_c = cnt_q[1] ^ cnt_q[3];
    assign prec_d = ~cnt_q[2];
endmodule // ocs_div_model

// *** test/tb_ocs_top.sv ***
// self-checking bench for the output clock stop and select top
`timescale 1ns/1ps
module tb_ocs_top;
    logic       clk = 1'b0, rst_n = 1'b0, reg_wr_en = 1'b0, reg_rd_en = 1'b0, pair = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
    logic [3:0] lock_flags = 4'h0;
    wire logic  [7:0] reg_rdata;
    wire logic  da, db, dc, gd, pc, pd, o0, o1, o2, o3, p0, p1;
    wire logic  [5:0] outs = {p1, p0, o3, o2, o1, o0};
    int         bad_count = 0, num_checks = 0;

    always #5 clk = ~clk;

    ocs_div_model u_ocs_div_model (.clk(clk), .rst_n(rst_n), .div_a(da), .div_b(db),
        .div_c(dc), .gen_d(gd), .prec_c(pc), .prec_d(pd));
    ocs_top u_ocs_top (.clk(clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .general_div_a(da),
        .general_div_b(db), .general_div_c(dc), .general_synth_divider_d(gd),
        .precision_div_c(pc), .precision_synth_divider_d(pd), .pair_two_three_diff(pair),
        .lock_loss_flags(lock_flags), .config_output_zero(o0), .config_output_one(o1),
        .config_output_two(o2), .config_output_three(o3), .precision_output_zero(p0),
        .precision_output_one(p1));

    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %0t read %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %0t level %b expected %b", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr_en = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr_en = 1'b0;
        repeat (20) @(negedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        reg_rd_en = 1'b1;
        reg_addr  = a;
        @(negedge clk);
        reg_rd_en = 1'b0;
        @(negedge clk);
        chk8(reg_rdata, exp);
    endtask

    // output must sit at one level for sixteen cycles while sources toggle
    task automatic hold(input int i, input logic v);
        repeat (16)
        begin
            @(negedge clk);
            chk1(outs[i], v);
        end
    endtask

    // output must show both levels within sixteen cycles
    task automatic runs(input int i);
        int n1, n0;
        n1 = 0;
        n0 = 0;
        repeat (16)
        begin
            @(negedge clk);
            n1 += int'(outs[i] === 1'b1);  // unknown levels count as neither
            n0 += int'(outs[i] === 1'b0);
        end
        chk1(n1 > 0 && n0 > 0 && n1 + n0 == 16, 1'b1);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs;
        rd(8'hb5, 8'h00);
        rd(8'hb7, 8'h00);
        rd(8'hb8, 8'h00);
        lock_flags = 4'h5;
        rd(8'hb9, 8'h05);
        wr(8'hb9, 8'haa);
        rd(8'hb9, 8'h05);
        wr(8'hb8, 8'hff);
        rd(8'hb8, 8'h0f);
        wr(8'hb5, 8'h3c);
        rd(8'hb5, 8'h3c);
        rd(8'h00, 8'h00);
        wr(8'hb8, 8'h00);
        wr(8'hb5, 8'h00);
    endtask

    task automatic t_gen;
        for (int f = 0; f < 4; f++)
        begin
            wr(8'hb7, 8'(2 << (2 * f)));
            hold(f, 1'b0);
            wr(8'hb7, 8'(3 << (2 * f)));
            hold(f, 1'b1);
            wr(8'hb7, 8'(1 << (2 * f)));
            runs(f);
        end
        wr(8'hb7, 8'h00);
    endtask

    task automatic t_prec;
        wr(8'hb8, 8'h0a);
        hold(4, 1'b0);
        hold(5, 1'b0);
        wr(8'hb5, 8'h40);
        hold(3, 1'b1);
        wr(8'hb8, 8'h0f);
        hold(4, 1'b1);
        hold(5, 1'b1);
        hold(3, 1'b0);
        wr(8'hb8, 8'h00);
        runs(3);
        runs(4);
        runs(5);
    endtask

    task automatic t_diff;
        pair = 1'b1;
        repeat (4) @(negedge clk);
        repeat (16) @(negedge clk) chk1(outs[3], ~outs[2]);
        runs(2);
        // reserved select must be ignored; output two's halt steers both
        wr(8'hb5, 8'hc0);
        wr(8'hb7, 8'h20);
        hold(2, 1'b0);
        hold(3, 1'b1);
        wr(8'hb7, 8'h00);
        pair = 1'b0;
        for (int c = 2; c < 4; c++)
        begin
            wr(8'hb5, 8'(c << 6));
            hold(3, 1'b0);
        end
        wr(8'hb5, 8'h00);
        runs(3);
    endtask

    // mid-run reset clears registers, read data and all outputs
    task automatic t_reset;
        wr(8'hb7, 8'h55);
        rd(8'hb7, 8'h55);
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        chk8({2'b00, outs}, 8'h00);
        rst_n = 1'b1;
        rd(8'hb7, 8'h00);
    endtask

    initial
    begin
        #200000;
        bad_count++;
        test_done();
    end

    initial
    begin
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        t_regs();
        t_gen();
        t_prec();
        t_reset();
        t_diff();
        test_done();
    end
endmodule // tb_ocs_top
